//--- pkg/rad_pkg.sv
/*
 * Constants, types and helpers for the remote I2C alias decoder.
 * Assumes a single 200 MHz clock domain and byte-wide register access.
 */
package rad_pkg;

    localparam int RAD_PORTS = 4;
    localparam int RAD_SLOTS = 3;

    localparam logic [7:0] RAD_OFS_PORT_SEL = 8'h4C;
    localparam logic [7:0] RAD_OFS_ALIAS0 = 8'h65;
    localparam logic [7:0] RAD_OFS_ALIAS1 = 8'h66;
    localparam logic [7:0] RAD_OFS_ALIAS2 = 8'h67;

    localparam logic [7:0] RAD_ALIAS_RESET = 8'h00;
    localparam logic [7:0] RAD_PORT_SEL_RESET = 8'h00;
    localparam logic [7:0] RAD_READ_UNMAPPED = 8'h00;

    // Field positions inside an alias byte
    localparam int RAD_ALIAS_MSB = 7;
    localparam int RAD_ALIAS_LSB = 1;
    localparam int RAD_AUTO_ACK_BIT = 0;
    // Port index field of the port select byte
    localparam int RAD_PSEL_MSB = 1;
    localparam int RAD_PSEL_LSB = 0;

    localparam logic [6:0] RAD_ALIAS_DISABLED = 7'h00;
    localparam logic [6:0] RAD_ADDR_NONE = 7'h00;

    typedef logic [1:0] rad_port_t;
    typedef logic [1:0] rad_slot_t;
    typedef logic [6:0] rad_addr_t;
    typedef logic [7:0] rad_byte_t;

    localparam rad_port_t RAD_PORT_RESET = 2'h0;
    localparam rad_slot_t RAD_SLOT_RESET = 2'h0;

    typedef enum logic [1:0] {
        RAD_SLOT0,
        RAD_SLOT1,
        RAD_SLOT2,
        RAD_SLOT_NONE
    } rad_hit_t;

    // Alias field of a slot byte
    function automatic rad_addr_t radAliasOf(input rad_byte_t b);
        return b[RAD_ALIAS_MSB:RAD_ALIAS_LSB];
    endfunction

    // A slot matches only when enabled; zero alias never matches
    function automatic logic radSlotHit(input rad_byte_t b, input rad_addr_t a);
        return (radAliasOf(b) != RAD_ALIAS_DISABLED) && (radAliasOf(b) == a);
    endfunction

    // Register offset to slot index, RAD_SLOT_NONE when not an alias byte
    function automatic rad_hit_t radSlotOfOffset(input rad_byte_t ofs);
        unique case (ofs)
            RAD_OFS_ALIAS0: return RAD_SLOT0;
            RAD_OFS_ALIAS1: return RAD_SLOT1;
            RAD_OFS_ALIAS2: return RAD_SLOT2;
            default: return RAD_SLOT_NONE;
        endcase
    endfunction

endpackage

//--- pkg/rad_match_if.sv
/*
 * Carrier between the decoder top and its alias matcher.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface rad_match_if;
    import rad_pkg::*;

    rad_byte_t aliasByte [RAD_SLOTS];
    rad_addr_t txnAddr;
    logic hit;
    rad_slot_t slot;
    logic autoAck;

    modport top (
        output aliasByte,
        output txnAddr,
        input hit,
        input slot,
        input autoAck
    );

    modport matcher (
        input aliasByte,
        input txnAddr,
        output hit,
        output slot,
        output autoAck
    );
endinterface

//--- rtl/rad_alias_match.sv
/*
 * Combinational alias matcher for the three slots of one receive port.
 * Assumes the top presents the alias bytes of the port that owns the
 * transaction; lowest slot wins if software programs duplicate aliases.
 */
`timescale 1ns/1ps
module rad_alias_match
    import rad_pkg::*;
(
    rad_match_if.matcher m
);

    always_comb begin
        m.hit = 1'b0;
        m.slot = 2'h0;
        m.autoAck = 1'b0;
        for (int s = RAD_SLOTS - 1; s >= 0; s--) begin
            if (radSlotHit(m.aliasByte[s], m.txnAddr)) begin
                m.hit = 1'b1;
                m.slot = 2'(s);
                m.autoAck = m.aliasByte[s][RAD_AUTO_ACK_BIT];
            end
        end
    end

endmodule // rad_alias_match

//--- rtl/rad_alias_decoder.sv
/*
 * Remote I2C alias decoder: per-port alias registers for three remote
 * target slots, alias match, remap to physical address, auto-acknowledge.
 * Assumes the device I2C target core delivers decoded register accesses
 * on the reg* port and decoded transaction addresses on the txn* port.
 * Physical addresses come from companion registers outside this block.
 */
`timescale 1ns/1ps

// Functional notes
// - Alias registers per port, chosen by port select
// - Bits 7:1 hold alias compared to address
// - Matched alias is replaced by physical address
// - Zero alias disables slot completely
// - Auto-ack bit acknowledges writes that match the slot, never reads
// - Slots at 0x65..0x67, reset to zero
// - Physical address is 7 bits, bits 7:1
module rad_alias_decoder
    import rad_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [7:0] physicalAddrSlot0 [RAD_PORTS],
    input wire logic [7:0] physicalAddrSlot1 [RAD_PORTS],
    input wire logic [7:0] physicalAddrSlot2 [RAD_PORTS],
    input wire logic txnValid,
    input wire logic [1:0] txnPort,
    input wire logic [6:0] txnAddr,
    input wire logic txnRead,
    output logic fwdValid,
    output logic [6:0] fwdAddr,
    output logic [1:0] fwdPort,
    output logic [1:0] fwdSlot,
    output logic fwdRead,
    output logic autoAck,
    output logic txnMiss,
    output logic [7:0] aliasAddrSlot0,
    output logic [7:0] aliasAddrSlot1,
    output logic [7:0] aliasAddrSlot2
);

    ////////////////////////////////////////////////////////////////////////
    // Register file

    rad_byte_t alias_r [RAD_PORTS][RAD_SLOTS];
    rad_byte_t alias_nxt [RAD_PORTS][RAD_SLOTS];
    rad_byte_t portSel_r;
    rad_byte_t portSel_nxt;
    rad_byte_t rdData_r;
    rad_byte_t rdData_nxt;
    logic rdValid_r;
    logic rdValid_nxt;
    rad_port_t selPort;
    rad_hit_t wrSlot;
    rad_hit_t rdSlot;
    logic selHit;

    assign selHit = (regAddr == RAD_OFS_PORT_SEL);
    assign selPort = portSel_r[RAD_PSEL_MSB:RAD_PSEL_LSB];
    assign wrSlot = radSlotOfOffset(regAddr);
    assign rdSlot = radSlotOfOffset(regAddr);

    // Writes land in the copy of the selected port
    always_comb begin
        alias_nxt = alias_r;
        portSel_nxt = portSel_r;
        if (regWrEn) begin
            if (selHit) begin
                portSel_nxt = regWrData;
            end else if (wrSlot != RAD_SLOT_NONE) begin
                alias_nxt[selPort][wrSlot] = regWrData;
            end
        end
    end

    // Same-cycle write is not seen by the read
    always_comb begin
        rdData_nxt = rdData_r;
        rdValid_nxt = regRdEn;
        if (regRdEn) begin
            if (selHit) begin
                rdData_nxt = portSel_r;
            end else if (rdSlot != RAD_SLOT_NONE) begin
                rdData_nxt = alias_r[selPort][rdSlot];
            end else begin
                rdData_nxt = RAD_READ_UNMAPPED;
            end
        end
    end

    // Write side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < RAD_PORTS; p++) begin
                for (int s = 0; s < RAD_SLOTS; s++) begin
                    alias_r[p][s] <= RAD_ALIAS_RESET;
                end
            end
            portSel_r <= RAD_PORT_SEL_RESET;
        end else begin
            alias_r <= alias_nxt;
            portSel_r <= portSel_nxt;
        end
    end

    // Read side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_r <= RAD_READ_UNMAPPED;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;
    assign aliasAddrSlot0 = alias_r[selPort][0];
    assign aliasAddrSlot1 = alias_r[selPort][1];
    assign aliasAddrSlot2 = alias_r[selPort][2];

    ////////////////////////////////////////////////////////////////////////
    // Alias match on the transaction's own port

    rad_match_if mIf ();

    always_comb begin
        for (int s = 0; s < RAD_SLOTS; s++) begin
            mIf.aliasByte[s] = alias_r[txnPort][s];
        end
        mIf.txnAddr = txnAddr;
    end

    rad_alias_match uMatch (
        .m(mIf.matcher)
    );

    ////////////////////////////////////////////////////////////////////////
    // Remap and forward

    rad_byte_t physByte;
    logic fwdValid_r;
    logic fwdValid_nxt;
    rad_addr_t fwdAddr_r;
    rad_addr_t fwdAddr_nxt;
    rad_port_t fwdPort_r;
    rad_port_t fwdPort_nxt;
    rad_slot_t fwdSlot_r;
    rad_slot_t fwdSlot_nxt;
    logic fwdRead_r;
    logic fwdRead_nxt;
    logic autoAck_r;
    logic autoAck_nxt;
    logic miss_r;
    logic miss_nxt;

    // Physical byte of the matched slot on the transaction's port
    always_comb begin
        unique case (mIf.slot)
            2'h0: physByte = physicalAddrSlot0[txnPort];
            2'h1: physByte = physicalAddrSlot1[txnPort];
            default: physByte = physicalAddrSlot2[txnPort];
        endcase
    end

    always_comb begin
        fwdValid_nxt = 1'b0;
        fwdAddr_nxt = fwdAddr_r;
        fwdPort_nxt = fwdPort_r;
        fwdSlot_nxt = fwdSlot_r;
        fwdRead_nxt = fwdRead_r;
        autoAck_nxt = 1'b0;
        miss_nxt = 1'b0;
        if (txnValid) begin
            if (mIf.hit) begin
                fwdValid_nxt = 1'b1;
                fwdAddr_nxt = radAliasOf(physByte);
                fwdPort_nxt = txnPort;
                fwdSlot_nxt = mIf.slot;
                fwdRead_nxt = txnRead;
                autoAck_nxt = mIf.autoAck && !txnRead;
            end else begin
                miss_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fwdValid_r <= 1'b0;
            fwdAddr_r <= RAD_ADDR_NONE;
            fwdPort_r <= RAD_PORT_RESET;
            fwdSlot_r <= RAD_SLOT_RESET;
            fwdRead_r <= 1'b0;
            autoAck_r <= 1'b0;
            miss_r <= 1'b0;
        end else begin
            fwdValid_r <= fwdValid_nxt;
            fwdAddr_r <= fwdAddr_nxt;
            fwdPort_r <= fwdPort_nxt;
            fwdSlot_r <= fwdSlot_nxt;
            fwdRead_r <= fwdRead_nxt;
            autoAck_r <= autoAck_nxt;
            miss_r <= miss_nxt;
        end
    end

    assign fwdValid = fwdValid_r;
    assign fwdAddr = fwdAddr_r;
    assign fwdPort = fwdPort_r;
    assign fwdSlot = fwdSlot_r;
    assign fwdRead = fwdRead_r;
    assign autoAck = autoAck_r;
    assign txnMiss = miss_r;

endmodule // rad_alias_decoder

//--- bench/rad_alias_decoder_asserts.sv
/* Port checker for the alias decoder.
   Bound to every decoder instance; single clock domain. */
`timescale 1ns/1ps
module rad_alias_decoder_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic txnValid,
    input wire logic [6:0] txnAddr,
    input wire logic txnRead,
    input wire logic fwdValid,
    input wire logic fwdRead,
    input wire logic autoAck,
    input wire logic txnMiss
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_rdAns; regRdEn |=> regRdValid; endproperty
    a_rdAns: assert property (p_rdAns) else $error("read not answered");
    property p_rdCause; regRdValid |-> $past(regRdEn); endproperty
    a_rdCause: assert property (p_rdCause) else $error("stray read answer");
    property p_unmapped;
        regRdEn && !(regAddr inside {8'h4C, 8'h65, 8'h66, 8'h67}) |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_oneAns; txnValid |=> fwdValid ^ txnMiss; endproperty
    a_oneAns: assert property (p_oneAns) else $error("bad txn answer");
    property p_ansCause; fwdValid || txnMiss |-> $past(txnValid); endproperty
    a_ansCause: assert property (p_ansCause) else $error("stray txn answer");
    property p_zeroAddr; txnValid && txnAddr == 7'h00 |=> txnMiss && !fwdValid; endproperty
    a_zeroAddr: assert property (p_zeroAddr) else $error("zero address matched");
    property p_ackWrite; autoAck |-> fwdValid && !fwdRead; endproperty
    a_ackWrite: assert property (p_ackWrite) else $error("auto ack not on write");
    property p_fwdRead; fwdValid |-> fwdRead == $past(txnRead); endproperty
    a_fwdRead: assert property (p_fwdRead) else $error("read flag lost");
    c_autoAck: cover property (fwdValid && autoAck);
    c_miss: cover property (txnMiss);
    c_read: cover property (regRdValid);
endmodule // rad_alias_decoder_asserts
////////////////////////////////////////////////////////////////////////////
bind rad_alias_decoder rad_alias_decoder_asserts i_rad_alias_decoder_asserts (.ref_clk, .rst,
    .regRdEn, .regAddr, .regRdData, .regRdValid, .txnValid, .txnAddr, .txnRead, .fwdValid,
    .fwdRead, .autoAck, .txnMiss);

//--- bench/rad_ctrl_model.sv
/* Local controller model: one address phase per bench request.
   Outside a request the lines show garbage, never the last value. */
`timescale 1ns/1ps
module rad_ctrl_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reqGo,
    input wire logic [1:0] reqPort,
    input wire logic [6:0] reqAddr,
    input wire logic reqRd,
    output logic txnValid,
    output logic [1:0] txnPort,
    output logic [6:0] txnAddr,
    output logic txnRead
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txnValid <= 1'b0;
            txnPort <= 2'h0;
            txnAddr <= 7'h00;
            txnRead <= 1'b0;
        end else begin
            txnValid <= reqGo;
            txnPort <= reqGo ? reqPort : ~txnPort;
            txnAddr <= reqGo ? reqAddr : ~txnAddr;
            txnRead <= reqGo ? reqRd : ~txnRead;
        end
    end
endmodule // rad_ctrl_model

//--- bench/tb_rad_alias_decoder.sv
/* Self-checking bench for the alias decoder.
   Drives registers directly and transactions through the controller model. */
`timescale 1ns/1ps
module tb_rad_alias_decoder;
    import rad_pkg::*;
    logic ref_clk = 1'b0, rst, regWrEn = 1'b0, regRdEn = 1'b0, reqGo = 1'b0, reqRd = 1'b0;
    logic [1:0] reqPort = 2'h0, psel, txnPort, fwdPort, fwdSlot;
    logic [6:0] reqAddr = 7'h00, txnAddr, fwdAddr;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic regRdValid, txnValid, txnRead, fwdValid, fwdRead, autoAck, txnMiss;
    logic [7:0] phys [RAD_SLOTS][RAD_PORTS];
    logic [7:0] aliasM [RAD_PORTS][RAD_SLOTS];
    logic [7:0] aliasOut [RAD_SLOTS];
    logic [15:0] lfsr = 16'hBF4D;
    int num_errors = 0;
    int checks_done = 0;
    always #2.5 ref_clk = ~ref_clk;
    rad_alias_decoder i_rad_alias_decoder (.ref_clk, .rst, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .physicalAddrSlot0(phys[0]),
        .physicalAddrSlot1(phys[1]), .physicalAddrSlot2(phys[2]), .txnValid, .txnPort,
        .txnAddr, .txnRead, .fwdValid, .fwdAddr, .fwdPort, .fwdSlot, .fwdRead, .autoAck,
        .txnMiss, .aliasAddrSlot0(aliasOut[0]), .aliasAddrSlot1(aliasOut[1]),
        .aliasAddrSlot2(aliasOut[2]));
    rad_ctrl_model i_rad_ctrl_model (.ref_clk, .rst, .reqGo, .reqPort, .reqAddr, .reqRd,
        .txnValid, .txnPort, .txnAddr, .txnRead);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsrNext(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Lowest enabled slot whose alias equals the address, 3 when none
    function automatic logic [1:0] expSlot(input logic [1:0] p, input logic [6:0] a);
        for (int s = 0; s < RAD_SLOTS; s++) begin
            if (aliasM[p][s][7:1] != 7'h00 && aliasM[p][s][7:1] == a) return 2'(s);
        end
        return 2'h3;
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
        if (a == RAD_OFS_PORT_SEL) psel = d[1:0];
        if (a >= RAD_OFS_ALIAS0 && a <= RAD_OFS_ALIAS2) aliasM[psel][a - RAD_OFS_ALIAS0] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(negedge ref_clk);
        chk("regRdValid", 8'(regRdValid), 8'h01);
        chk("regRdData", regRdData, e);
        @(posedge ref_clk);
    endtask
    task automatic txn(input logic [1:0] p, input logic [6:0] a, input logic r);
        logic [1:0] s;
        s = expSlot(p, a);
        reqGo <= 1'b1;
        reqPort <= p;
        reqAddr <= a;
        reqRd <= r;
        @(posedge ref_clk);
        reqGo <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("fwdValid", 8'(fwdValid), 8'(s != 2'h3));
        chk("txnMiss", 8'(txnMiss), 8'(s == 2'h3));
        if (s != 2'h3) begin
            chk("fwdAddr", 8'(fwdAddr), 8'(phys[s][p][7:1]));
            chk("fwdSlot", 8'(fwdSlot), 8'(s));
            chk("fwdPort", 8'(fwdPort), 8'(p));
            chk("autoAck", 8'(autoAck), 8'(aliasM[p][s][0] & ~r));
            chk("fwdRead", 8'(fwdRead), 8'(r));
        end
        @(posedge ref_clk);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 2'h0;
        for (int i = 0; i < RAD_PORTS * RAD_SLOTS; i++) begin
            lfsr = lfsrNext(lfsr);
            phys[i % RAD_SLOTS][i / RAD_SLOTS] = lfsr[7:0];
            aliasM[i / RAD_SLOTS][i % RAD_SLOTS] = 8'h00;
        end
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(RAD_OFS_PORT_SEL, 8'h00);
        for (int s = 0; s < RAD_SLOTS; s++) rd(RAD_OFS_ALIAS0 + 8'(s), 8'h00);
        wr(8'h68, 8'hFF);
        rd(8'h68, 8'h00);
        for (int i = 0; i < RAD_PORTS * RAD_SLOTS; i++) begin
            lfsr = lfsrNext(lfsr);
            if (i % RAD_SLOTS == 0) wr(RAD_OFS_PORT_SEL, 8'(i / RAD_SLOTS));
            wr(RAD_OFS_ALIAS0 + 8'(i % RAD_SLOTS), lfsr[7:0]);
        end
        // Port 2: auto-ack slot, disabled slot with ack bit, duplicate alias
        wr(RAD_OFS_PORT_SEL, 8'h02);
        wr(RAD_OFS_ALIAS0, 8'h55);
        wr(RAD_OFS_ALIAS1, 8'h01);
        wr(RAD_OFS_ALIAS2, 8'h55);
        for (int i = 0; i < RAD_PORTS * RAD_SLOTS; i++) begin
            if (i % RAD_SLOTS == 0) wr(RAD_OFS_PORT_SEL, 8'(i / RAD_SLOTS));
            rd(RAD_OFS_ALIAS0 + 8'(i % RAD_SLOTS), aliasM[i / RAD_SLOTS][i % RAD_SLOTS]);
            chk("aliasOut", aliasOut[i % RAD_SLOTS], aliasM[i / RAD_SLOTS][i % RAD_SLOTS]);
        end
        txn(2'h2, 7'h2A, 1'b0);
        txn(2'h2, 7'h2A, 1'b1);
        for (int p = 0; p < RAD_PORTS; p++) txn(2'(p), 7'h00, 1'b0);
        repeat (60) begin
            lfsr = lfsrNext(lfsr);
            txn(lfsr[1:0], lfsr[2] ? aliasM[lfsr[1:0]][lfsr[4:3] % 3][7:1] : lfsr[14:8], lfsr[5]);
        end
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        psel = 2'h0;
        for (int i = 0; i < RAD_PORTS * RAD_SLOTS; i++) begin
            aliasM[i / RAD_SLOTS][i % RAD_SLOTS] = 8'h00;
        end
        @(posedge ref_clk);
        rd(RAD_OFS_PORT_SEL, 8'h00);
        rd(RAD_OFS_ALIAS0, 8'h00);
        for (int s = 0; s < RAD_SLOTS; s++) chk("aliasOut", aliasOut[s], 8'h00);
        txn(2'h2, 7'h2A, 1'b0);
        print_verdict;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        num_errors++;
        print_verdict;
    end
endmodule // tb_rad_alias_decoder
